/* File: analog_ref_pkg.sv */
// Constants for the analog reference, temperature sensor and ladder converter control.
// Assumes a 32-bit Wishbone register bus with word-aligned registers.
package analog_ref_pkg;

    // ********************************************************************
    // Register map.
    // ********************************************************************
    localparam logic [3:0] REF_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] CONV_CTRL_ADDR  = 4'h4;
    localparam logic [3:0] CONV_LEVEL_ADDR = 4'h8;
    localparam logic [3:0] PIN_CTRL_ADDR   = 4'hC;

    // ********************************************************************
    // Field positions.
    // ********************************************************************
    localparam int REF_EN_BIT     = 7;
    localparam int REF_RDY_BIT    = 6;
    localparam int TS_EN_BIT      = 5;
    localparam int TS_RNG_BIT     = 4;
    localparam int CMP_GAIN_LSB   = 2;
    localparam int ADC_GAIN_LSB   = 0;
    localparam int CONV_EN_BIT    = 7;
    localparam int OUT_A_BIT      = 5;
    localparam int OUT_B_BIT      = 4;
    localparam int UPPER_SEL_LSB  = 2;
    localparam int LOWER_SEL_BIT  = 0;
    localparam int SLEEP_BIT      = 0;
    localparam int LEVEL_W        = 5;

    // Writable-bit masks; reserved bits read as zero.
    localparam logic [7:0] REF_CTRL_WMASK  = 8'hBF;
    localparam logic [7:0] CONV_CTRL_WMASK = 8'hBD;
    localparam logic [7:0] CONV_LEVEL_MASK = 8'h1F;
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // Upper ladder source codes.
    localparam logic [1:0] UPPER_SUPPLY    = 2'h0;
    localparam logic [1:0] UPPER_EXT_REF   = 2'h1;
    localparam logic [1:0] UPPER_FIXED_REF = 2'h2;
    localparam logic [1:0] UPPER_RESERVED  = 2'h3;

    // Gain code for a buffer that is off.
    localparam logic [1:0] GAIN_OFF = 2'h0;

    // ********************************************************************
    // Timing.
    // ********************************************************************
    localparam int CLK_MHZ         = 50;
    localparam int REF_SETTLE_US   = 25;
    localparam int REF_SETTLE_CYC  = REF_SETTLE_US * CLK_MHZ;
    localparam int SETTLE_W        = 11;
    localparam int TS_SETTLE_US    = 200;
    localparam int TS_SETTLE_CYC   = TS_SETTLE_US * CLK_MHZ;

endpackage

/* File: analog_reference_control.sv */
// Control logic for the fixed reference, temperature sensor and 5-bit ladder converter.
// Assumes a classic Wishbone master on the core clock; analog parts sit behind the outputs.
// How it works
// - Reference enable bit powers reference and buffers.
// - Ready flag rises only after settle time.
// - Each gain field selects 1x, 2x or 4x.
// - Sensor enable bit powers the sensor.
// - Range bit set selects high range.
// - Range bit clear selects low range.
// - Sensor output routed to its ADC channel.
// - Converter works only when enable bit set.
// - Five-bit level code picks one of 32 taps.
// - Upper source: fixed reference, external, supply.
// - Upper code 11 reserved, 10/01/00 sources.
// - Lower source: external negative or ground.
// - Lower bit 1 external, 0 ground.
// - Output routed to comparator, ADC, pins.
// - Each pin carries level when enabled.
// - Enabled pin loses driver, pull-up, input.
// - Digital read of such pin returns zero.
// - Sleep wake keeps converter control unchanged.
// - Reset disables converter, pins, clears level.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module analog_reference_control (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_pin_a_in,
    input  wire logic        i_pin_b_in,
    input  wire logic        i_pin_a_gpio_out,
    input  wire logic        i_pin_b_gpio_out,
    input  wire logic        i_pin_a_gpio_oe_n,
    input  wire logic        i_pin_b_gpio_oe_n,
    input  wire logic        i_pin_a_pullup,
    input  wire logic        i_pin_b_pullup,
    output logic             o_pin_a_out,
    output logic             o_pin_b_out,
    output logic             o_pin_a_oe_n,
    output logic             o_pin_b_oe_n,
    output logic             o_pin_a_pullup,
    output logic             o_pin_b_pullup,
    output logic             o_pin_a_din,
    output logic             o_pin_b_din,
    output logic             o_pin_a_analog,
    output logic             o_pin_b_analog,
    output logic             o_ref_power,
    output logic [1:0]       o_adc_gain,
    output logic [1:0]       o_cmp_gain,
    output logic             o_ts_power,
    output logic             o_ts_high_range,
    output logic             o_ts_to_adc,
    output logic             o_conv_power,
    output logic [4:0]       o_level_tap,
    output logic [1:0]       o_upper_src,
    output logic             o_lower_ext,
    output logic             o_conv_to_periph,
    output logic             o_sleep_req
);
    // ********************************************************************
    // Register state.
    // ********************************************************************
    logic [7:0]  ref_ctrl_r,   ref_ctrl_nxt;
    logic [7:0]  conv_ctrl_r,  conv_ctrl_nxt;
    logic [7:0]  conv_level_r, conv_level_nxt;
    logic        sleep_r,      sleep_nxt;
    logic        ack_r,        ack_nxt;
    logic [31:0] rdat_r,       rdat_nxt;
    logic        ready;
    settle_if    ref_settle ();

    settle_timer #(
        .CYCLES (analog_ref_pkg::REF_SETTLE_CYC)
    ) u_ref_settle (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .port       (ref_settle.timer)
    );

    // Timer counts from the enable bit, starting one cycle before the registered o_ref_power output rises.
    assign ref_settle.start = ref_ctrl_r[analog_ref_pkg::REF_EN_BIT];
    assign ready            = ref_settle.done;

    // Merges a byte-lane-0 write into a register under its writable mask.
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d,
                                         input logic sel0, input logic [7:0] m);
        logic [7:0] r;
        r = old;
        if (sel0) begin
            r = (old & ~m) | (d[7:0] & m);
        end
        return r;
    endfunction

    // ********************************************************************
    // Bus slave.
    // ********************************************************************
    logic access;
    logic wr;
    assign access = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr     = access && i_wb_we;

    always_comb begin
        ref_ctrl_nxt   = ref_ctrl_r;
        conv_ctrl_nxt  = conv_ctrl_r;
        conv_level_nxt = conv_level_r;
        sleep_nxt      = sleep_r;
        ack_nxt        = access;
        rdat_nxt       = '0;
        if (wr) begin
            unique case (i_wb_adr)
                analog_ref_pkg::REF_CTRL_ADDR: begin
                    ref_ctrl_nxt = merge(ref_ctrl_r, i_wb_dat, i_wb_sel[0],
                                         analog_ref_pkg::REF_CTRL_WMASK);
                end
                analog_ref_pkg::CONV_CTRL_ADDR: begin
                    conv_ctrl_nxt = merge(conv_ctrl_r, i_wb_dat, i_wb_sel[0],
                                          analog_ref_pkg::CONV_CTRL_WMASK);
                end
                analog_ref_pkg::CONV_LEVEL_ADDR: begin
                    conv_level_nxt = merge(conv_level_r, i_wb_dat, i_wb_sel[0],
                                           analog_ref_pkg::CONV_LEVEL_MASK);
                end
                analog_ref_pkg::PIN_CTRL_ADDR: begin
                    if (i_wb_sel[0]) begin
                        sleep_nxt = i_wb_dat[analog_ref_pkg::SLEEP_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
        if (access && !i_wb_we) begin
            unique case (i_wb_adr)
                analog_ref_pkg::REF_CTRL_ADDR: begin
                    rdat_nxt[7:0] = ref_ctrl_r;
                    rdat_nxt[analog_ref_pkg::REF_RDY_BIT] = ready;
                end
                analog_ref_pkg::CONV_CTRL_ADDR: begin
                    rdat_nxt[7:0] = conv_ctrl_r;
                end
                analog_ref_pkg::CONV_LEVEL_ADDR: begin
                    rdat_nxt[7:0] = conv_level_r;
                end
                analog_ref_pkg::PIN_CTRL_ADDR: begin
                    rdat_nxt[analog_ref_pkg::SLEEP_BIT] = sleep_r;
                end
                default: begin
                    rdat_nxt = '0;
                end
            endcase
        end
    end

    // Sleep request never touches the converter control register.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ref_ctrl_r   <= analog_ref_pkg::CTRL_RESET;
            conv_ctrl_r  <= analog_ref_pkg::CTRL_RESET;
            conv_level_r <= analog_ref_pkg::CTRL_RESET;
            sleep_r      <= 1'b0;
            ack_r        <= 1'b0;
            rdat_r       <= '0;
        end else begin
            ref_ctrl_r   <= ref_ctrl_nxt;
            conv_ctrl_r  <= conv_ctrl_nxt;
            conv_level_r <= conv_level_nxt;
            sleep_r      <= sleep_nxt;
            ack_r        <= ack_nxt;
            rdat_r       <= rdat_nxt;
        end
    end

    // ********************************************************************
    // Analog and pin controls.
    // ********************************************************************
    logic       conv_en, oe_a, oe_b;
    logic [1:0] upper;
    assign conv_en = conv_ctrl_r[analog_ref_pkg::CONV_EN_BIT];
    assign oe_a    = conv_ctrl_r[analog_ref_pkg::OUT_A_BIT];
    assign oe_b    = conv_ctrl_r[analog_ref_pkg::OUT_B_BIT];
    assign upper   = conv_ctrl_r[analog_ref_pkg::UPPER_SEL_LSB +: 2];

    logic        ref_pw_nxt, ts_pw_nxt, ts_hi_nxt, conv_pw_nxt, lower_nxt;
    logic [1:0]  adc_g_nxt, cmp_g_nxt, upper_nxt;
    logic [4:0]  tap_nxt;
    logic        a_out_nxt, b_out_nxt, a_oen_nxt, b_oen_nxt, a_pu_nxt, b_pu_nxt;
    logic        a_din_nxt, b_din_nxt, a_an_nxt, b_an_nxt;

    always_comb begin
        ref_pw_nxt  = ref_ctrl_r[analog_ref_pkg::REF_EN_BIT];
        adc_g_nxt   = ref_pw_nxt ? ref_ctrl_r[analog_ref_pkg::ADC_GAIN_LSB +: 2]
                                 : analog_ref_pkg::GAIN_OFF;
        cmp_g_nxt   = ref_pw_nxt ? ref_ctrl_r[analog_ref_pkg::CMP_GAIN_LSB +: 2]
                                 : analog_ref_pkg::GAIN_OFF;
        ts_pw_nxt   = ref_ctrl_r[analog_ref_pkg::TS_EN_BIT];
        ts_hi_nxt   = ref_ctrl_r[analog_ref_pkg::TS_RNG_BIT];
        conv_pw_nxt = conv_en;
        tap_nxt     = conv_en ? conv_level_r[analog_ref_pkg::LEVEL_W-1:0] : '0;
        // Reserved code falls back to the supply source, driven out as UPPER_SUPPLY.
        upper_nxt   = (upper == analog_ref_pkg::UPPER_RESERVED)
                      ? analog_ref_pkg::UPPER_SUPPLY : upper;
        lower_nxt   = conv_ctrl_r[analog_ref_pkg::LOWER_SEL_BIT];
        a_an_nxt    = conv_en && oe_a;
        b_an_nxt    = conv_en && oe_b;
        a_out_nxt   = oe_a ? 1'b0 : i_pin_a_gpio_out;
        b_out_nxt   = oe_b ? 1'b0 : i_pin_b_gpio_out;
        a_oen_nxt   = oe_a ? 1'b1 : i_pin_a_gpio_oe_n;
        b_oen_nxt   = oe_b ? 1'b1 : i_pin_b_gpio_oe_n;
        a_pu_nxt    = oe_a ? 1'b0 : i_pin_a_pullup;
        b_pu_nxt    = oe_b ? 1'b0 : i_pin_b_pullup;
        a_din_nxt   = oe_a ? 1'b0 : i_pin_a_in;
        b_din_nxt   = oe_b ? 1'b0 : i_pin_b_in;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_ref_power      <= 1'b0;
            o_adc_gain       <= analog_ref_pkg::GAIN_OFF;
            o_cmp_gain       <= analog_ref_pkg::GAIN_OFF;
            o_ts_power       <= 1'b0;
            o_ts_high_range  <= 1'b0;
            o_ts_to_adc      <= 1'b0;
            o_conv_power     <= 1'b0;
            o_level_tap      <= '0;
            o_upper_src      <= analog_ref_pkg::UPPER_SUPPLY;
            o_lower_ext      <= 1'b0;
            o_conv_to_periph <= 1'b0;
            o_pin_a_analog   <= 1'b0;
            o_pin_b_analog   <= 1'b0;
            o_pin_a_out      <= 1'b0;
            o_pin_b_out      <= 1'b0;
            o_pin_a_oe_n     <= 1'b1;
            o_pin_b_oe_n     <= 1'b1;
            o_pin_a_pullup   <= 1'b0;
            o_pin_b_pullup   <= 1'b0;
            o_pin_a_din      <= 1'b0;
            o_pin_b_din      <= 1'b0;
            o_sleep_req      <= 1'b0;
        end else begin
            o_ref_power      <= ref_pw_nxt;
            o_adc_gain       <= adc_g_nxt;
            o_cmp_gain       <= cmp_g_nxt;
            o_ts_power       <= ts_pw_nxt;
            o_ts_high_range  <= ts_hi_nxt;
            o_ts_to_adc      <= ts_pw_nxt;
            o_conv_power     <= conv_pw_nxt;
            o_level_tap      <= tap_nxt;
            o_upper_src      <= upper_nxt;
            o_lower_ext      <= lower_nxt;
            o_conv_to_periph <= conv_pw_nxt;
            o_pin_a_analog   <= a_an_nxt;
            o_pin_b_analog   <= b_an_nxt;
            o_pin_a_out      <= a_out_nxt;
            o_pin_b_out      <= b_out_nxt;
            o_pin_a_oe_n     <= a_oen_nxt;
            o_pin_b_oe_n     <= b_oen_nxt;
            o_pin_a_pullup   <= a_pu_nxt;
            o_pin_b_pullup   <= b_pu_nxt;
            o_pin_a_din      <= a_din_nxt;
            o_pin_b_din      <= b_din_nxt;
            o_sleep_req      <= sleep_r;
        end
    end

    assign o_wb_dat = rdat_r;
    assign o_wb_ack = ack_r;
endmodule
`default_nettype wire

/* File: analog_reference_control_props.sv */
// Concurrent checks on the ports of the analog reference control block.
// Assumes analog_ref_pkg and analog_reference_control are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module analog_reference_control_chk (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [3:0]  i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_pin_a_out,
    input wire logic        o_pin_a_oe_n,
    input wire logic        o_pin_a_pullup,
    input wire logic        o_pin_a_din,
    input wire logic        o_pin_a_analog,
    input wire logic        o_pin_b_analog,
    input wire logic        o_ref_power,
    input wire logic [1:0]  o_adc_gain,
    input wire logic [1:0]  o_cmp_gain,
    input wire logic        o_ts_power,
    input wire logic        o_ts_to_adc,
    input wire logic        o_conv_power,
    input wire logic [4:0]  o_level_tap,
    input wire logic [1:0]  o_upper_src
);
    // ********************************************************************
    // Cycles since the reference was powered, saturating.
    // ********************************************************************
    localparam int READY_MIN = analog_ref_pkg::REF_SETTLE_CYC - 8;
    logic [15:0] on_cnt_r;
    logic [15:0] on_cnt_nxt;
    logic        ref_read;
    always_comb begin
        on_cnt_nxt = on_cnt_r;
        if (!o_ref_power) on_cnt_nxt = 16'h0000;
        else if (on_cnt_r != 16'hFFFF) on_cnt_nxt = on_cnt_r + 16'h0001;
        ref_read = o_wb_ack && !i_wb_we && i_wb_adr == analog_ref_pkg::REF_CTRL_ADDR;
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) on_cnt_r <= 16'h0000;
        else on_cnt_r <= on_cnt_nxt;
    end
    // ********************************************************************
    // Properties.
    // ********************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_ack_answer; (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
    property p_upper_zero; (o_wb_ack && !i_wb_we) |-> o_wb_dat[31:8] == 24'h00_0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_gain_off; !o_ref_power |-> (o_adc_gain == 2'h0 && o_cmp_gain == 2'h0); endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain buffer on with ref off");
    property p_ts_route; o_ts_to_adc == o_ts_power; endproperty
    a_ts_route: assert property (p_ts_route) else $error("sensor route differs from power");
    property p_tap_off; !o_conv_power |-> o_level_tap == 5'h00; endproperty
    a_tap_off: assert property (p_tap_off) else $error("tap selected while disabled");
    property p_upper_rsvd; o_upper_src != analog_ref_pkg::UPPER_RESERVED; endproperty
    a_upper_rsvd: assert property (p_upper_rsvd) else $error("reserved source driven");
    property p_pin_override; o_pin_a_analog [*3] |-> (o_pin_a_oe_n && !o_pin_a_out
        && !o_pin_a_pullup && !o_pin_a_din); endproperty
    a_pin_override: assert property (p_pin_override) else $error("pin a not overridden");
    property p_ready_off; (ref_read && !o_ref_power && !$past(o_ref_power)
        && !$past(o_ref_power, 2)) |-> !o_wb_dat[6]; endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready read with ref off");
    property p_ready_late; (ref_read && o_wb_dat[6]) |-> int'(on_cnt_r) >= READY_MIN; endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready before settle time");
    property p_reset_clear; $rose(i_rst_n) |-> (!o_conv_power && o_level_tap == 5'h00
        && !o_pin_a_analog && !o_pin_b_analog && !o_ref_power && o_pin_a_oe_n); endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");
endmodule

bind analog_reference_control analog_reference_control_chk i_chk (
    .i_core_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
    .o_pin_a_out, .o_pin_a_oe_n, .o_pin_a_pullup, .o_pin_a_din, .o_pin_a_analog,
    .o_pin_b_analog, .o_ref_power, .o_adc_gain, .o_cmp_gain, .o_ts_power, .o_ts_to_adc,
    .o_conv_power, .o_level_tap, .o_upper_src
);
`default_nettype wire

/* File: settle_if.sv */
// Carries one settle request and its done flag between the control top and the timer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface settle_if;
    logic start;
    logic done;
    modport ctrl  (output start, input done);
    modport timer (input start, output done);
endinterface
`default_nettype wire

/* File: settle_timer.sv */
// Stabilisation timer: counts while start is high, raises done after the settle time.
// Assumes start stays high for as long as the unit is powered.
`timescale 1ns/100ps
`default_nettype none
module settle_timer #(
    parameter int CYCLES = analog_ref_pkg::REF_SETTLE_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    settle_if.timer   port
);
    logic [analog_ref_pkg::SETTLE_W-1:0] cnt_r;
    logic [analog_ref_pkg::SETTLE_W-1:0] cnt_nxt;
    logic                                done_r;
    logic                                done_nxt;

    localparam logic [analog_ref_pkg::SETTLE_W-1:0] LAST =
        analog_ref_pkg::SETTLE_W'(CYCLES - 1);

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (!port.start) begin
            cnt_nxt  = '0;
            done_nxt = 1'b0;
        end else if (!done_r) begin
            if (cnt_r == LAST) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign port.done = done_r;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the analog reference control block.
// Assumes the design, its package and the bound checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic [3:0] adr; logic [7:0] wd; logic [7:0] rd; logic [31:0] snap;} row_t;
    logic i_core_clk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [3:0] i_wb_adr, i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, q;
    logic i_pin_a_in, i_pin_b_in, i_pin_a_gpio_out, i_pin_b_gpio_out, i_pin_a_gpio_oe_n;
    logic i_pin_b_gpio_oe_n, i_pin_a_pullup, i_pin_b_pullup, o_pin_a_out, o_pin_b_out;
    logic o_pin_a_oe_n, o_pin_b_oe_n, o_pin_a_pullup, o_pin_b_pullup, o_pin_a_din, o_pin_b_din;
    logic o_pin_a_analog, o_pin_b_analog, o_ref_power, o_ts_power, o_ts_high_range, o_ts_to_adc;
    logic o_conv_power, o_lower_ext, o_conv_to_periph, o_sleep_req;
    logic [1:0] o_adc_gain, o_cmp_gain, o_upper_src;
    logic [4:0] o_level_tap;
    int mismatches = 0;
    int checks = 0;
    row_t rows [13] = '{'{4'h0, 8'h0F, 8'h0F, 32'h0000_0000}, '{4'h0, 8'h3E, 8'h3E, 32'h0000_E000},
        '{4'h0, 8'h86, 8'h86, 32'h0016_0000}, '{4'h4, 8'hFF, 8'hBD, 32'h0016_101E},
        '{4'h8, 8'hFF, 8'h1F, 32'h0016_1F9E}, '{4'h4, 8'h88, 8'h88, 32'h0016_1FC8},
        '{4'h4, 8'h04, 8'h04, 32'h0016_0020}, '{4'h4, 8'h80, 8'h80, 32'h0016_1F88},
        '{4'h8, 8'hAA, 8'h0A, 32'h0016_1508}, '{4'h0, 8'h06, 8'h06, 32'h0000_1508},
        '{4'hC, 8'h01, 8'h01, 32'h0000_1509}, '{4'hC, 8'h00, 8'h00, 32'h0000_1508},
        '{4'h1, 8'hFF, 8'h00, 32'h0000_1508}};

    analog_reference_control i_dut (
        .i_core_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel,
        .o_wb_dat, .o_wb_ack, .i_pin_a_in, .i_pin_b_in, .i_pin_a_gpio_out, .i_pin_b_gpio_out,
        .i_pin_a_gpio_oe_n, .i_pin_b_gpio_oe_n, .i_pin_a_pullup, .i_pin_b_pullup, .o_pin_a_out,
        .o_pin_b_out, .o_pin_a_oe_n, .o_pin_b_oe_n, .o_pin_a_pullup, .o_pin_b_pullup,
        .o_pin_a_din, .o_pin_b_din, .o_pin_a_analog, .o_pin_b_analog, .o_ref_power, .o_adc_gain,
        .o_cmp_gain, .o_ts_power, .o_ts_high_range, .o_ts_to_adc, .o_conv_power, .o_level_tap,
        .o_upper_src, .o_lower_ext, .o_conv_to_periph, .o_sleep_req
    );

    // ********************************************************************
    // Helpers.
    // ********************************************************************
    function automatic logic [31:0] snap();
        return {11'h000, o_ref_power, o_cmp_gain, o_adc_gain, o_ts_power, o_ts_high_range,
            o_ts_to_adc, o_conv_power, o_level_tap, o_upper_src, o_lower_ext, o_conv_to_periph,
            o_pin_a_analog, o_pin_b_analog, o_sleep_req};
    endfunction
    function automatic logic [31:0] pins();
        return {24'h00_0000, o_pin_a_out, o_pin_a_oe_n, o_pin_a_pullup, o_pin_a_din,
            o_pin_b_out, o_pin_b_oe_n, o_pin_b_pullup, o_pin_b_din};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic set_pins(input logic [7:0] v);
        {i_pin_a_gpio_out, i_pin_a_gpio_oe_n, i_pin_a_pullup, i_pin_a_in} <= v[7:4];
        {i_pin_b_gpio_out, i_pin_b_gpio_oe_n, i_pin_b_pullup, i_pin_b_in} <= v[3:0];
        repeat (3) @(posedge i_core_clk);
    endtask
    // One classic Wishbone cycle; the request is held until ack is sampled high.
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        int n;
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= a;
        i_wb_dat <= {24'h00_0000, d};
        i_wb_sel <= s;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 64);
        r = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
        if (o_wb_ack !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // ********************************************************************
    // Main sequence.
    // ********************************************************************
    initial begin
        i_rst_n = 1'b0;
        {i_wb_cyc, i_wb_stb, i_wb_we} = 3'h0;
        i_wb_adr = 4'h0;
        i_wb_dat = 32'h0000_0000;
        i_wb_sel = 4'h0;
        {i_pin_a_gpio_out, i_pin_a_gpio_oe_n, i_pin_a_pullup, i_pin_a_in} = 4'hB;
        {i_pin_b_gpio_out, i_pin_b_gpio_oe_n, i_pin_b_pullup, i_pin_b_in} = 4'h4;
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            bus(rows[i].adr, 1'b1, rows[i].wd, 4'hF, q);
            bus(rows[i].adr, 1'b0, 8'h00, 4'hF, q);
            check("readback", {24'h00_0000, rows[i].rd}, q);
            check("outputs", rows[i].snap, snap());
        end
        set_pins(8'hB4);
        check("pins", 32'h0000_00B4, pins());
        set_pins(8'h4B);
        check("pins", 32'h0000_004B, pins());
        set_pins(8'hBB);
        bus(analog_ref_pkg::CONV_CTRL_ADDR, 1'b1, 8'hA0, 4'hF, q);
        repeat (3) @(posedge i_core_clk);
        check("pins", 32'h0000_004B, pins());
        check("analog", 32'h0000_0002, {30'h0, o_pin_a_analog, o_pin_b_analog});
        bus(analog_ref_pkg::CONV_CTRL_ADDR, 1'b1, 8'h10, 4'hF, q);
        repeat (3) @(posedge i_core_clk);
        check("pins", 32'h0000_00B4, pins());
        check("analog", 32'h0000_0000, {30'h0, o_pin_a_analog, o_pin_b_analog});
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b1, 8'h06, 4'hF, q);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("ref off", 32'h0000_0006, q);
        check("gains", 32'h0000_0000, {28'h0, o_cmp_gain, o_adc_gain});
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b1, 8'hC6, 4'hF, q);
        repeat (1200) @(posedge i_core_clk);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("early ready", 32'h0000_0086, q);
        repeat (60) @(posedge i_core_clk);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("ready", 32'h0000_00C6, q);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b1, 8'h46, 4'hF, q);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("ready cleared", 32'h0000_0006, q);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b1, 8'h86, 4'hF, q);
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("ready restart", 32'h0000_0086, q);
        bus(analog_ref_pkg::CONV_LEVEL_ADDR, 1'b1, 8'h03, 4'hE, q);
        bus(analog_ref_pkg::CONV_LEVEL_ADDR, 1'b0, 8'h00, 4'hF, q);
        check("masked write", 32'h0000_000A, q);
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        check("reset outputs", 32'h0000_0000, snap());
        check("reset pins", 32'h0000_0044, pins());
        for (int k = 0; k < 4; k++) begin
            bus(4'(k * 4), 1'b0, 8'h00, 4'hF, q);
            check("reset reg", 32'h0000_0000, q);
        end
        bus(analog_ref_pkg::REF_CTRL_ADDR, 1'b1, 8'h20, 4'hF, q);
        repeat (analog_ref_pkg::TS_SETTLE_CYC) @(posedge i_core_clk);
        check("sensor", 32'h0000_A000, snap());
        repeat (analog_ref_pkg::TS_SETTLE_CYC) @(posedge i_core_clk);
        check("sensor", 32'h0000_A000, snap());
        test_done();
    end
endmodule
`default_nettype wire
